// *** design/fps_consts.vh ***
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

// Register byte addresses
`define FPS_ADDR_CONTROL 8'h00
`define FPS_ADDR_KEY 8'h04
`define FPS_ADDR_TABLE_PAGE 8'h08
`define FPS_ADDR_TABLE_OFFSET 8'h0c
`define FPS_ADDR_STATUS 8'h10

// Control field positions
`define FPS_BIT_START 15
`define FPS_BIT_PROG_EN 14
`define FPS_BIT_SEQ_ERR 13
`define FPS_BIT_PGM_ONLY 12
`define FPS_BIT_ERASE 6
`define FPS_OP_MSB 5

// Reset values
`define FPS_CONTROL_RESET 16'h0000
`define FPS_TABLE_PAGE_RESET 8'h00
`define FPS_TABLE_OFFSET_RESET 16'h0000

// Unlock keys
`define FPS_KEY_FIRST 8'h55
`define FPS_KEY_SECOND 8'haa

// Operation codes
`define FPS_OP_ERASE_4ROW 6'h1a
`define FPS_OP_ERASE_2ROW 6'h19
`define FPS_OP_ERASE_1ROW 6'h18
`define FPS_OP_GRP_BOOT 4'ha
`define FPS_OP_GRP_ALL 4'h9
`define FPS_OP_GRP_CONFIG 4'h5
`define FPS_OP_GRP_EEPROM 4'h4
`define FPS_OP_GRP_GENERAL 4'h3
`define FPS_OP_GRP_ROW_WRITE 4'h1

// Array geometry
`define FPS_ROW_WORDS 32
`define FPS_ROW_BYTES 96

// Operation kinds toward the array
`define FPS_KIND_NONE 3'h0
`define FPS_KIND_ROW_ERASE 3'h1
`define FPS_KIND_ROW_WRITE 3'h2
`define FPS_KIND_CONFIG_ERASE 3'h3
`define FPS_KIND_EEPROM_ERASE 3'h4
`define FPS_KIND_GENERAL_ERASE 3'h5
`define FPS_KIND_BOOT_ERASE 3'h6
`define FPS_KIND_CHIP_ERASE 3'h7

// Timing
`define FPS_OP_TIME_US 2000
`define FPS_CLK_MHZ 20
`define FPS_UNLOCK_WINDOW 2

`endif

// *** design/fps_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"

module fps_decode
(
    input wire [5:0] op_code,
    input wire erase_sel,
    input wire serial_mode,
    output reg [2:0] kind,
    output reg [2:0] row_count
);
    always @*
    begin
        kind = `FPS_KIND_NONE;
        row_count = 3'h0;
        if (erase_sel)
        begin
            if (op_code == `FPS_OP_ERASE_4ROW)
            begin
                kind = `FPS_KIND_ROW_ERASE;
                row_count = 3'h4;
            end
            else if (op_code == `FPS_OP_ERASE_2ROW)
            begin
                kind = `FPS_KIND_ROW_ERASE;
                row_count = 3'h2;
            end
            else if (op_code == `FPS_OP_ERASE_1ROW)
            begin
                kind = `FPS_KIND_ROW_ERASE;
                row_count = 3'h1;
            end
            else
            begin
                case (op_code[5:2])
                    `FPS_OP_GRP_BOOT: kind = serial_mode ? `FPS_KIND_BOOT_ERASE : `FPS_KIND_NONE;
                    `FPS_OP_GRP_ALL: kind = serial_mode ? `FPS_KIND_CHIP_ERASE : `FPS_KIND_NONE;
                    `FPS_OP_GRP_CONFIG: kind = `FPS_KIND_CONFIG_ERASE;
                    `FPS_OP_GRP_EEPROM: kind = `FPS_KIND_EEPROM_ERASE;
                    `FPS_OP_GRP_GENERAL: kind = `FPS_KIND_GENERAL_ERASE;
                    default: kind = `FPS_KIND_NONE;
                endcase
            end
        end
        else if (op_code[5:2] == `FPS_OP_GRP_ROW_WRITE)
        begin
            kind = `FPS_KIND_ROW_WRITE;
            row_count = 3'h1;
        end
    end
endmodule // fps_decode

`default_nettype wire

// *** design/fps_sequencer.v ***
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"

module fps_sequencer #(
    parameter OP_CYCLES = (`FPS_OP_TIME_US * `FPS_CLK_MHZ),
    parameter UNLOCK_WINDOW = `FPS_UNLOCK_WINDOW
)
(
    input wire clk,
    input wire rst_n,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hsel,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire serial_programming_mode,
    input wire abort_req,
    input wire array_done,
    output wire cpu_stall,
    output reg op_start_ff,
    output reg [2:0] op_kind_ff,
    output reg [2:0] op_rows_ff,
    output reg [23:0] op_addr_ff,
    output reg op_active_ff
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_DONE = 2'd2;
    localparam [1:0] KEY_NONE = 2'd0;
    localparam [1:0] KEY_HALF = 2'd1;
    localparam [1:0] KEY_OPEN = 2'd2;
    localparam [31:0] OP_CNT_MAX = OP_CYCLES;
    localparam [15:0] CTRL_RST = `FPS_CONTROL_RESET;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [1:0] key_state_ff;
    reg [1:0] nxt_key_state;
    reg [7:0] window_ff;
    reg [7:0] nxt_window;
    reg start_ff;
    reg nxt_start;
    reg prog_en_ff;
    reg nxt_prog_en;
    reg seq_err_ff;
    reg nxt_seq_err;
    reg pgm_only_ff;
    reg nxt_pgm_only;
    reg erase_ff;
    reg nxt_erase;
    reg [5:0] op_code_ff;
    reg [5:0] nxt_op_code;
    reg [7:0] table_page_ff;
    reg [15:0] table_offset_ff;
    reg [31:0] cnt_ff;
    reg [31:0] nxt_cnt;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    reg wr_pend_ff;
    reg rd_pend_ff;
    reg [7:0] addr_ff;
    reg last_ok_ff;
    reg nxt_last_ok;
    reg nxt_op_start;
    reg [2:0] nxt_op_kind;
    reg [2:0] nxt_op_rows;
    reg [23:0] nxt_op_addr;

    wire [2:0] dec_kind;
    wire [2:0] dec_rows;
    wire addr_phase;
    wire wr_ctrl;
    wire wr_key;
    wire [15:0] wdat;
    wire [15:0] ctrl_view;
    wire start_attempt;
    wire start_ok;
    wire [5:0] dec_code;
    wire dec_erase;
    reg [7:0] nxt_table_page;
    reg [15:0] nxt_table_offset;
    reg nxt_wr_pend;
    reg nxt_rd_pend;
    reg [7:0] nxt_addr;

    fps_decode u_decode
    (
        .op_code(dec_code),
        .erase_sel(dec_erase),
        .serial_mode(serial_programming_mode),
        .kind(dec_kind),
        .row_count(dec_rows)
    );

    // Writes complete in one data-phase cycle; reads need one wait state
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout = ~rd_pend_ff;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign wdat = hwdata[15:0];
    assign wr_ctrl = wr_pend_ff && (addr_ff == `FPS_ADDR_CONTROL);
    assign wr_key = wr_pend_ff && (addr_ff == `FPS_ADDR_KEY);
    assign cpu_stall = (state_ff != ST_IDLE);
    assign ctrl_view = {start_ff, prog_en_ff, seq_err_ff, pgm_only_ff, 5'h00, erase_ff, op_code_ff};
    assign start_attempt = wr_ctrl && wdat[`FPS_BIT_START] && !start_ff;
    // Unlock open and enable set in the very same write count as valid
    assign start_ok = start_attempt && (key_state_ff == KEY_OPEN) && wdat[`FPS_BIT_PROG_EN];
    // Launch decodes the word being written, so one write both selects and starts
    assign dec_code = wdat[`FPS_OP_MSB:0];
    assign dec_erase = wdat[`FPS_BIT_ERASE];

    always @*
    begin
        nxt_key_state = key_state_ff;
        nxt_window = window_ff;
        case (key_state_ff)
            KEY_NONE:
            begin
                if (wr_key && wdat[7:0] == `FPS_KEY_FIRST)
                    nxt_key_state = KEY_HALF;
            end
            KEY_HALF:
            begin
                if (wr_key && wdat[7:0] == `FPS_KEY_SECOND)
                begin
                    nxt_key_state = KEY_OPEN;
                    nxt_window = UNLOCK_WINDOW[7:0];
                end
                else if (wr_key && wdat[7:0] == `FPS_KEY_FIRST)
                    nxt_key_state = KEY_HALF;
                else if (wr_pend_ff)
                    nxt_key_state = KEY_NONE;
            end
            KEY_OPEN:
            begin
                if (window_ff == 8'h00)
                    nxt_key_state = KEY_NONE;
                else
                    nxt_window = window_ff - 8'h01;
                // Any other write, the control write too, spends the unlock
                if (wr_key && wdat[7:0] == `FPS_KEY_FIRST)
                    nxt_key_state = KEY_HALF;
                else if (wr_pend_ff)
                    nxt_key_state = KEY_NONE;
            end
            default: nxt_key_state = KEY_NONE;
        endcase
    end

    always @*
    begin
        nxt_state = state_ff;
        nxt_start = start_ff;
        nxt_prog_en = prog_en_ff;
        nxt_seq_err = seq_err_ff;
        nxt_pgm_only = pgm_only_ff;
        nxt_erase = erase_ff;
        nxt_op_code = op_code_ff;
        nxt_cnt = cnt_ff;
        nxt_last_ok = last_ok_ff;
        nxt_op_start = 1'b0;
        nxt_op_kind = op_kind_ff;
        nxt_op_rows = op_rows_ff;
        nxt_op_addr = op_addr_ff;
        if (wr_ctrl && state_ff == ST_IDLE)
        begin
            nxt_prog_en = wdat[`FPS_BIT_PROG_EN];
            nxt_pgm_only = wdat[`FPS_BIT_PGM_ONLY];
            nxt_erase = wdat[`FPS_BIT_ERASE];
            nxt_op_code = wdat[`FPS_OP_MSB:0];
            if (!wdat[`FPS_BIT_SEQ_ERR])
                nxt_seq_err = 1'b0;
        end
        case (state_ff)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    nxt_start = 1'b1;
                    nxt_seq_err = 1'b0;
                    nxt_state = ST_RUN;
                    nxt_cnt = 32'h0;
                    nxt_op_kind = dec_kind;
                    nxt_op_rows = dec_rows;
                    // Base taken from table pointer as is, with no row alignment
                    nxt_op_addr = {table_page_ff, table_offset_ff};
                    nxt_op_start = (dec_kind != `FPS_KIND_NONE);
                end
                else if (start_attempt)
                    nxt_seq_err = 1'b1;
            end
            ST_RUN:
            begin
                nxt_cnt = cnt_ff + 32'h1;
                if (abort_req)
                begin
                    nxt_seq_err = 1'b1;
                    nxt_last_ok = 1'b0;
                    nxt_state = ST_DONE;
                end
                else if ((cnt_ff + 32'h1 >= OP_CNT_MAX) &&
                         (array_done || op_kind_ff == `FPS_KIND_NONE))
                begin
                    nxt_last_ok = 1'b1;
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                nxt_start = 1'b0;
                nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @*
    begin
        nxt_rdata = 32'h0;
        case (addr_ff)
            `FPS_ADDR_CONTROL: nxt_rdata = {16'h0000, ctrl_view};
            `FPS_ADDR_KEY: nxt_rdata = 32'h0;
            `FPS_ADDR_TABLE_PAGE: nxt_rdata = {24'h0, table_page_ff};
            `FPS_ADDR_TABLE_OFFSET: nxt_rdata = {16'h0, table_offset_ff};
            `FPS_ADDR_STATUS: nxt_rdata = {28'h0, last_ok_ff, key_state_ff == KEY_OPEN, state_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    always @*
    begin
        nxt_wr_pend = addr_phase && hwrite;
        nxt_rd_pend = addr_phase && !hwrite;
        nxt_addr = addr_ff;
        nxt_table_page = table_page_ff;
        nxt_table_offset = table_offset_ff;
        if (addr_phase)
            nxt_addr = haddr[7:0];
        // Pointer frozen while an operation runs
        if (wr_pend_ff && state_ff == ST_IDLE)
        begin
            if (addr_ff == `FPS_ADDR_TABLE_PAGE)
                nxt_table_page = hwdata[7:0];
            if (addr_ff == `FPS_ADDR_TABLE_OFFSET)
                nxt_table_offset = hwdata[15:0];
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            rdata_ff <= 32'h0;
            table_page_ff <= `FPS_TABLE_PAGE_RESET;
            table_offset_ff <= `FPS_TABLE_OFFSET_RESET;
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
            addr_ff <= nxt_addr;
            table_page_ff <= nxt_table_page;
            table_offset_ff <= nxt_table_offset;
            // Read data stays put until the next read
            if (rd_pend_ff)
                rdata_ff <= nxt_rdata;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            key_state_ff <= KEY_NONE;
            window_ff <= 8'h00;
            start_ff <= CTRL_RST[`FPS_BIT_START];
            prog_en_ff <= CTRL_RST[`FPS_BIT_PROG_EN];
            seq_err_ff <= CTRL_RST[`FPS_BIT_SEQ_ERR];
            pgm_only_ff <= CTRL_RST[`FPS_BIT_PGM_ONLY];
            erase_ff <= CTRL_RST[`FPS_BIT_ERASE];
            op_code_ff <= CTRL_RST[`FPS_OP_MSB:0];
            cnt_ff <= 32'h0;
            last_ok_ff <= 1'b0;
            op_start_ff <= 1'b0;
            op_kind_ff <= `FPS_KIND_NONE;
            op_rows_ff <= 3'h0;
            op_addr_ff <= 24'h0;
            op_active_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            key_state_ff <= nxt_key_state;
            window_ff <= nxt_window;
            start_ff <= nxt_start;
            prog_en_ff <= nxt_prog_en;
            seq_err_ff <= nxt_seq_err;
            pgm_only_ff <= nxt_pgm_only;
            erase_ff <= nxt_erase;
            op_code_ff <= nxt_op_code;
            cnt_ff <= nxt_cnt;
            last_ok_ff <= nxt_last_ok;
            op_start_ff <= nxt_op_start;
            op_kind_ff <= nxt_op_kind;
            op_rows_ff <= nxt_op_rows;
            op_addr_ff <= nxt_op_addr;
            op_active_ff <= (nxt_state == ST_RUN);
        end
    end
endmodule // fps_sequencer

`default_nettype wire

// *** tb/fps_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_array_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_active,
    input wire logic slow,
    output logic array_done
);
    logic [7:0] age_ff;
    always @(posedge clk)
    begin
        if (!rst_n || !op_active)
            age_ff <= 8'h0;
        else if (age_ff != 8'hff)
            age_ff <= age_ff + 8'h1;
    end
    // Slow case outlasts the minimum so the array, not the timer, ends the run
    assign array_done = op_active && (age_ff >= (slow ? 8'h14 : 8'h1));
endmodule // fps_array_model
`default_nettype wire

// *** tb/fps_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"
module fps_seq_checker #(parameter OP_CYCLES = 8)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hsel,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic abort_req,
    input wire logic serial_programming_mode,
    input wire logic cpu_stall,
    input wire logic op_start_ff,
    input wire logic [2:0] op_kind_ff,
    input wire logic [2:0] op_rows_ff,
    input wire logic op_active_ff
);
    logic wph_ff;
    logic [7:0] wad_ff;
    logic [1:0] kst_ff;
    logic [15:0] cnt_ff;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wph_ff <= 1'h0;
            kst_ff <= 2'h0;
            cnt_ff <= 16'h0;
        end
        else
        begin
            if (hready)
            begin
                wph_ff <= hsel && htrans[1] && hwrite;
                wad_ff <= haddr[7:0];
            end
            // Any write other than the key pair breaks the unlock
            if (wph_ff)
                kst_ff <= (wad_ff != `FPS_ADDR_KEY) ? 2'h0 : (hwdata[7:0] == `FPS_KEY_FIRST) ? 2'h1 :
                    (hwdata[7:0] == `FPS_KEY_SECOND && kst_ff == 2'h1) ? 2'h2 : 2'h0;
            cnt_ff <= op_active_ff ? cnt_ff + 16'h1 : 16'h0;
        end
    end
    wire ctl_wr = wph_ff && wad_ff == `FPS_ADDR_CONTROL;
    wire ctl_go = ctl_wr && hwdata[15:14] == 2'h3 && kst_ff == 2'h2;
    wire ctl_bad = ctl_wr && hwdata[15] && !cpu_stall && !ctl_go;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_req; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
    sequence s_wr_req; hsel && hready && htrans[1] && hwrite; endsequence
    a_read_wait: assert property (s_rd_req |=> s_rd_ans)
        else $error("read answer timing wrong");
    a_write_nowait: assert property (s_wr_req |=> hreadyout)
        else $error("write data phase stalled");
    a_start_unlocked: assert property (op_start_ff |-> $past(ctl_go) || $past(ctl_go, 2))
        else $error("launch without unlock");
    a_bad_refused: assert property (ctl_bad |=> !op_start_ff [*2])
        else $error("bad start launched");
    a_stall_running: assert property (op_active_ff |-> cpu_stall)
        else $error("cpu not stalled");
    a_min_time: assert property ($fell(op_active_ff) |-> cnt_ff >= OP_CYCLES - 1 || $past(abort_req))
        else $error("operation ended early");
    a_rows_legal: assert property (op_start_ff && op_kind_ff == `FPS_KIND_ROW_ERASE |->
        op_rows_ff inside {3'h1, 3'h2, 3'h4}) else $error("bad row count");
    a_kind_defined: assert property (op_start_ff |-> op_kind_ff != `FPS_KIND_NONE)
        else $error("launch of no operation");
    a_bulk_serial: assert property (op_start_ff && op_kind_ff >= `FPS_KIND_BOOT_ERASE |->
        serial_programming_mode) else $error("bulk erase outside serial mode");
endmodule // fps_seq_checker
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fps_consts.vh"
module testbench;
    logic clk = 1'h0, rst_n = 1'h0, hwrite = 1'h0, hsel = 1'h0, slow = 1'h0, rdp = 1'h0;
    logic serial_programming_mode = 1'h0, abort_req = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, array_done, cpu_stall, op_start_ff, op_active_ff;
    wire [2:0] op_kind_ff, op_rows_ff;
    wire [23:0] op_addr_ff;
    int fail_count = 0, total_checks = 0;
    logic [31:0] rd_q[$], mk_q[$], op_q[$];
    logic [31:0] ctl[12] = '{32'h405a, 32'h4059, 32'h4058, 32'h4054, 32'h5050, 32'h404e,
        32'h4006, 32'h4068, 32'h4065, 32'h4068, 32'h4060, 32'h4018};
    // Serial mode, kind, rows
    logic [7:0] ex[12] = '{8'h14, 8'h12, 8'h11, 8'h30, 8'h40, 8'h50, 8'h20, 8'he0, 8'hf0, 8'h00, 8'h00, 8'h00};
    fps_sequencer #(.OP_CYCLES(8)) u_dut (.clk, .rst_n, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_programming_mode, .abort_req, .array_done,
        .cpu_stall, .op_start_ff, .op_kind_ff, .op_rows_ff, .op_addr_ff, .op_active_ff);
    fps_array_model u_arr (.clk, .rst_n, .op_active(op_active_ff), .slow, .array_done);
    always #25 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back(e & m);
        mk_q.push_back(m);
        xfer(1'h0, a, 32'h0);
    endtask
    task automatic key(input int md);
        if (md != 0) wr(`FPS_ADDR_KEY, 32'h55);
        if (md == 2) wr(`FPS_ADDR_TABLE_PAGE, {25'h0, rnd[22:16]});
        if (md != 0) wr(`FPS_ADDR_KEY, 32'haa);
        if (md == 3) repeat (2) rd(`FPS_ADDR_STATUS, 32'h0, 32'h0);
    endtask
    task automatic idle;
        repeat (2) @(posedge clk);
        while (cpu_stall !== 1'h0) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (rdp && hreadyout)
            chk(hrdata & mk_q.pop_front(), rd_q.pop_front());
        if (hreadyout)
            rdp = hsel && htrans[1] && !hwrite;
        // A launch nobody asked for meets an impossible note
        if (op_start_ff === 1'h1)
            chk({2'h0, op_kind_ff, op_kind_ff == 3'h1 ? op_rows_ff : 3'h0, op_addr_ff},
                op_q.size() > 0 ? op_q.pop_front() : 32'hffffffff);
        if (hresp !== 1'h0)
            chk({31'h0, hresp}, 32'h0);
    end
    initial
    begin
        #300000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h35f6));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(`FPS_ADDR_CONTROL, 32'h0, 32'hffff);
        rd(`FPS_ADDR_KEY, 32'h0, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        $display("Test reset values done");
        for (int i = 0; i < 12; i++)
        begin
            rnd = $urandom;
            wr(`FPS_ADDR_TABLE_PAGE, {25'h0, rnd[22:16]});
            wr(`FPS_ADDR_TABLE_OFFSET, {16'h0, rnd[15:0]});
            serial_programming_mode <= ex[i][7];
            slow <= i[0];
            if (ex[i][6:4] != 3'h0)
                op_q.push_back({2'h0, ex[i][6:4], ex[i][2:0], 1'h0, rnd[22:0]});
            key(1);
            wr(`FPS_ADDR_CONTROL, ctl[i] | 32'h8000);
            idle();
            rd(`FPS_ADDR_CONTROL, ctl[i] & 32'h707f, ex[i][6:4] != 3'h0 ? 32'hffff : 32'hdfff);
        end
        $display("Test operation codes done");
        for (int m = 0; m < 4; m++)
        begin
            key(m);
            wr(`FPS_ADDR_CONTROL, m == 1 ? 32'h8058 : 32'hc058);
            idle();
            rd(`FPS_ADDR_CONTROL, 32'h2000, 32'ha000);
            wr(`FPS_ADDR_CONTROL, 32'h0058);
            rd(`FPS_ADDR_CONTROL, 32'h0, 32'h2000);
        end
        $display("Test refused starts done");
        op_q.push_back({2'h0, 3'h1, 3'h1, 1'h0, rnd[22:0]});
        op_q.push_back({2'h0, 3'h2, 3'h0, 1'h0, rnd[22:0]});
        rd(`FPS_ADDR_TABLE_PAGE, {25'h0, rnd[22:16]}, 32'hffffffff);
        for (int s = 0; s < 2; s++)
        begin
            key(1);
            wr(`FPS_ADDR_CONTROL, s == 0 ? 32'hc058 : 32'hc006);
            idle();
        end
        $display("Test row rewrite done");
        slow <= 1'h1;
        op_q.push_back({2'h0, 3'h1, 3'h1, 1'h0, rnd[22:0]});
        key(1);
        wr(`FPS_ADDR_CONTROL, 32'hc058);
        wr(`FPS_ADDR_CONTROL, 32'h4058);
        rd(`FPS_ADDR_CONTROL, 32'h8000, 32'h8000);
        abort_req <= 1'h1;
        idle();
        abort_req <= 1'h0;
        rd(`FPS_ADDR_CONTROL, 32'h2000, 32'ha000);
        $display("Test abort done");
        wrap_up();
    end
endmodule // testbench
bind fps_sequencer fps_seq_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (.clk, .rst_n, .haddr, .htrans, .hwrite, .hwdata,
    .hsel, .hready, .hreadyout, .abort_req, .serial_programming_mode, .cpu_stall, .op_start_ff, .op_kind_ff,
    .op_rows_ff, .op_active_ff);
`default_nettype wire
